// ===== hdl/tone_event_interrupt_fifo.sv
// tone event interrupt queue with axi4-lite register access
//
// Behaviour
// - pending bit 7 reads one while any tone event remains queued.
// - reading the queue register pops the returned entry, acting as acknowledge.
// - pending zero means nothing outstanding and the queue is empty.
// - bits 6 and 5 of the queue register always read zero.
// - after reset the queue register reads 00, queue empty.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module tone_event_interrupt_fifo
    import tone_irq_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire tone_event_t       tone_evt_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    output logic                   irq_o
);
    // =====================================================
    // event queue
    logic [CODE_W-1:0] mem_q [QUEUE_DEPTH];
    logic [PTR_W-1:0]  wr_ptr_q;
    logic [PTR_W-1:0]  rd_ptr_q;
    logic [PTR_W:0]    count_q;
    logic              push;
    logic              pop;
    logic              empty;
    logic              full;
    logic [7:0]        queue_view;

    // count carries one bit more than the pointers so a full queue is never taken for empty
    assign empty = (count_q == '0);
    assign full  = (count_q == (PTR_W+1)'(QUEUE_DEPTH));
    // an event arriving while full is dropped and flagged as overflow
    assign push  = tone_evt_i.valid && !full;

    // storage has no reset; an empty queue forces the code field to zero instead
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= tone_evt_i.code;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    // pending flag, two zero bits, oldest code
    always_comb begin
        queue_view              = QUEUE_RESET;
        queue_view[PENDING_BIT] = !empty;
        queue_view[6:5]         = 2'b00;
        queue_view[CODE_W-1:0]  = empty ? '0 : mem_q[rd_ptr_q];
    end

    // =====================================================
    // test register, status and mask
    logic [7:0]      test_q;
    logic [ST_W-1:0] status_q;
    logic [ST_W-1:0] mask_q;
    logic [ST_W-1:0] status_set;
    logic [ST_W-1:0] w1c;
    logic            wr_fire;
    logic [13:0]     wr_addr_q;
    logic [31:0]     wr_data_q;
    logic [3:0]      wr_strb_q;

    always_comb begin
        status_set               = '0;
        status_set[ST_EVENT_BIT] = push;
        status_set[ST_OVFL_BIT]  = tone_evt_i.valid && full;
        // the test bit lets software force the interrupt line without a detector
        status_set[ST_TEST_BIT]  = test_q[TEST_IRQ_BIT];
    end

    always_comb begin
        w1c = '0;
        if (wr_fire && wr_addr_q == IRQ_STATUS_ADDR && wr_strb_q[0]) begin
            w1c = wr_data_q[ST_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            status_q <= '0;
        end else begin
            // a set in the same cycle as its clear wins
            status_q <= (status_q & ~w1c) | status_set;
        end
    end

    // all eight test bits are stored; only bit 0 has an effect
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            test_q <= TEST_RESET;
            mask_q <= '0;
        end else if (wr_fire && wr_strb_q[0]) begin
            if (wr_addr_q == INTERRUPT_TEST_CONTROL_ADDR) begin
                test_q <= wr_data_q[7:0];
            end
            if (wr_addr_q == IRQ_MASK_ADDR) begin
                mask_q <= wr_data_q[ST_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            // built from the next status, so irq rises on the same edge as its status bit
            irq_o <= |((status_q & ~w1c | status_set) & mask_q);
        end
    end

    // =====================================================
    // axi4-lite write channel: address and data taken in either order
    logic aw_have_q;
    logic w_have_q;

    // nothing new is taken while a response waits: one write at a time
    assign s_axi_awready_o = !aw_have_q && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_have_q && !s_axi_bvalid_o;
    assign wr_fire         = aw_have_q && w_have_q && !s_axi_bvalid_o;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            aw_have_q      <= 1'b0;
            w_have_q       <= 1'b0;
            wr_addr_q      <= '0;
            wr_data_q      <= '0;
            wr_strb_q      <= '0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_have_q <= 1'b1;
                wr_addr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_have_q  <= 1'b1;
                wr_data_q <= s_axi_wdata_i;
                wr_strb_q <= s_axi_wstrb_i;
            end
            if (wr_fire) begin
                aw_have_q      <= 1'b0;
                w_have_q       <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                // the queue register is read-only; writes there are ignored
                unique case (wr_addr_q)
                    TONE_EVENT_QUEUE_ADDR, INTERRUPT_TEST_CONTROL_ADDR,
                    IRQ_STATUS_ADDR, IRQ_MASK_ADDR: s_axi_bresp_o <= RESP_OKAY;
                    default:                        s_axi_bresp_o <= RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // =====================================================
    // axi4-lite read channel: one-cycle answer, pop on acceptance of a queue read
    logic rd_take;

    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign rd_take         = s_axi_arvalid_i && s_axi_arready_o;
    // the head is captured and popped on one edge, so no later read can return it again
    assign pop             = rd_take && s_axi_araddr_i == TONE_EVENT_QUEUE_ADDR && !empty;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= '0;
            s_axi_rresp_o  <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o  <= RESP_OKAY;
            // unmapped places read zero with an error, so a stray address cannot pass for an empty queue
            unique case (s_axi_araddr_i)
                TONE_EVENT_QUEUE_ADDR:       s_axi_rdata_o <= {24'h000000, queue_view};
                INTERRUPT_TEST_CONTROL_ADDR: s_axi_rdata_o <= {24'h000000, test_q};
                IRQ_STATUS_ADDR:             s_axi_rdata_o <= {29'h00000000, status_q};
                IRQ_MASK_ADDR:               s_axi_rdata_o <= {29'h00000000, mask_q};
                default: begin
                    s_axi_rdata_o <= '0;
                    s_axi_rresp_o <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // =====================================================
    // checks
    chk_pending_tracks_queue: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        queue_view[PENDING_BIT] == (count_q != '0))
        else $error("pending flag disagrees with queue fill");

    chk_pop_on_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        pop && !push |=> count_q == $past(count_q) - 1'b1)
        else $error("queue read did not remove one entry");

    chk_zero_means_empty: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        s_axi_rvalid_o && $past(pop) == 1'b0 && s_axi_rdata_o[PENDING_BIT] == 1'b0
        && $past(rd_take) && $past(s_axi_araddr_i) == TONE_EVENT_QUEUE_ADDR
        |-> s_axi_rdata_o[4:0] == 5'h00 && $past(count_q) == '0)
        else $error("pending clear but the queue held entries");

    chk_unused_bits_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $past(rd_take) && $past(s_axi_araddr_i) == TONE_EVENT_QUEUE_ADDR |-> s_axi_rdata_o[6:5] == 2'b00)
        else $error("unused queue bits read nonzero");

    chk_reset_empty: assert property (@(posedge clk_sys_i)
        $past(rst_i) |-> count_q == '0 && queue_view == QUEUE_RESET)
        else $error("queue not empty after reset");

    chk_push_on_event: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        push && !pop |=> count_q == $past(count_q) + 1'b1)
        else $error("tone event was not queued");

    chk_oldest_first: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        empty && push ##1 !pop |-> queue_view[4:0] == $past(tone_evt_i.code))
        else $error("head of queue is not the first event");

    chk_read_response: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rd_take |=> s_axi_rvalid_o)
        else $error("read not answered in one cycle");

    // answers are checked one cycle after the edge that accepted the read
    chk_pending_on_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $past(rd_take) && $past(s_axi_araddr_i) == TONE_EVENT_QUEUE_ADDR
        |-> s_axi_rdata_o[PENDING_BIT] == ($past(count_q) != '0))
        else $error("returned pending flag disagrees with queue fill");

    chk_queue_read_okay: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $past(rd_take) && $past(s_axi_araddr_i) == TONE_EVENT_QUEUE_ADDR |-> s_axi_rresp_o == RESP_OKAY)
        else $error("queue read answered with an error");

    chk_count_holds_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !push && !pop |=> count_q == $past(count_q))
        else $error("queue fill changed without a push or a pop");

    chk_empty_stays: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        empty && !push |=> empty)
        else $error("empty queue gained an entry without an event");

    chk_reset_clears: assert property (@(posedge clk_sys_i)
        rst_i |=> count_q == '0 && !irq_o && !s_axi_rvalid_o && !s_axi_bvalid_o)
        else $error("reset left state behind");

    chk_full_drops_event: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tone_evt_i.valid && full |=> status_q[ST_OVFL_BIT] && count_q <= $past(count_q))
        else $error("event into a full queue was not dropped and flagged");

    chk_event_sets_status: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        push |=> status_q[ST_EVENT_BIT] && queue_view[PENDING_BIT])
        else $error("queued event left status or pending flag clear");

    chk_irq_follows_status: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        irq_o == |(status_q & $past(mask_q)))
        else $error("irq output disagrees with unmasked status");

    chk_status_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_fire && wr_addr_q == IRQ_STATUS_ADDR && wr_strb_q[0]
        |=> (status_q & $past(wr_data_q[ST_W-1:0]) & ~$past(status_set)) == '0)
        else $error("written one did not clear its status bit");

    chk_mask_write_lands: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_fire && wr_addr_q == IRQ_MASK_ADDR && wr_strb_q[0] |=> mask_q == $past(wr_data_q[ST_W-1:0]))
        else $error("mask write did not land");

    chk_write_answer: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_fire |=> s_axi_bvalid_o)
        else $error("write not answered one cycle after both halves were held");
endmodule
`default_nettype wire

// ===== hdl/tone_irq_pkg.sv
// package: register map, field layout and sizes for the tone event interrupt queue
package tone_irq_pkg;
    // printed offsets are not multiples of four: they are indices, byte address = 4 * index
    localparam logic [11:0] TONE_EVENT_QUEUE_IDX       = 12'h410;
    localparam logic [11:0] INTERRUPT_TEST_CONTROL_IDX = 12'h411;
    localparam logic [11:0] IRQ_STATUS_IDX             = 12'h412;
    localparam logic [11:0] IRQ_MASK_IDX               = 12'h413;
    localparam logic [13:0] TONE_EVENT_QUEUE_ADDR       = {TONE_EVENT_QUEUE_IDX, 2'b00};
    localparam logic [13:0] INTERRUPT_TEST_CONTROL_ADDR = {INTERRUPT_TEST_CONTROL_IDX, 2'b00};
    localparam logic [13:0] IRQ_STATUS_ADDR             = {IRQ_STATUS_IDX, 2'b00};
    localparam logic [13:0] IRQ_MASK_ADDR               = {IRQ_MASK_IDX, 2'b00};
    localparam int          ADDR_W        = 14;
    localparam int          CODE_W        = 5;
    localparam int          QUEUE_DEPTH   = 32;
    localparam int          PTR_W         = 5;
    localparam int          PENDING_BIT   = 7;
    localparam int          TEST_IRQ_BIT  = 0;
    localparam logic [7:0]  QUEUE_RESET   = 8'h00;
    localparam logic [7:0]  TEST_RESET    = 8'h00;
    // status/mask bit layout
    localparam int          ST_EVENT_BIT  = 0;
    localparam int          ST_OVFL_BIT   = 1;
    localparam int          ST_TEST_BIT   = 2;
    localparam int          ST_W          = 3;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    typedef struct packed {
        logic                valid;
        logic [CODE_W-1:0]   code;
    } tone_event_t;
endpackage

// ===== dv/testbench.sv
// self-checking testbench for the tone event interrupt queue
`timescale 1ns/1ns
`default_nettype none
module testbench
    import tone_irq_pkg::*;
;
    logic              clk;
    logic              rst;
    tone_event_t       evt;
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic              awready;
    logic [31:0]       wdata;
    logic              wvalid;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready;
    logic              irq;
    int                fails;
    int                check_count;
    logic [31:0]       rd;
    logic [1:0]        rs;

    tone_event_interrupt_fifo i_tone_event_interrupt_fifo (
        .clk_sys_i(clk), .rst_i(rst), .tone_evt_i(evt),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .irq_o(irq)
    );

    // ==========================================================
    // clock and closing report
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // ==========================================================
    // bus tasks: each starts one edge later so no signal is assigned twice in a time step
    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n >= 200) begin
            fails++;
            end_of_test();
        end
    endtask

    task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n >= 200) begin
            fails++;
            end_of_test();
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        fails = 0;
        check_count = 0;
        rst = 1'b1;
        evt = '0;
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        axi_read(TONE_EVENT_QUEUE_ADDR, rd, rs);
        chk("queue after reset", 32'h00, rd);
        axi_read(INTERRUPT_TEST_CONTROL_ADDR, rd, rs);
        chk("test after reset", 32'h00, rd);
        // one event more than the depth: the last is dropped and flags overflow
        for (int i = 0; i <= QUEUE_DEPTH; i++) begin
            @(posedge clk);
            evt <= '{valid: 1'b1, code: i[CODE_W-1:0]};
        end
        @(posedge clk);
        evt <= '0;
        axi_read(IRQ_STATUS_ADDR, rd, rs);
        chk("status overflow", 32'h03, rd);
        @(posedge clk);
        #1 chk("irq masked", 32'h0, {31'h0, irq});
        // oldest first, pending set, bits 6:5 zero, each read pops one
        for (int i = 0; i < QUEUE_DEPTH; i++) begin
            axi_read(TONE_EVENT_QUEUE_ADDR, rd, rs);
            chk("queue entry", {24'h0, 3'b100, i[4:0]}, rd);
        end
        axi_read(TONE_EVENT_QUEUE_ADDR, rd, rs);
        chk("queue drained", 32'h00, rd);
        // reading an empty queue pops nothing, the next event is returned alone
        @(posedge clk);
        evt <= '{valid: 1'b1, code: 5'h05};
        @(posedge clk);
        evt <= '0;
        axi_read(TONE_EVENT_QUEUE_ADDR, rd, rs);
        chk("single event", 32'h85, rd);
        axi_read(TONE_EVENT_QUEUE_ADDR, rd, rs);
        chk("single popped", 32'h00, rd);
        // interrupt: unmask, then clear by writing ones
        axi_write(IRQ_MASK_ADDR, 32'h01, rs);
        repeat (2) @(posedge clk);
        #1 chk("irq raised", 32'h1, {31'h0, irq});
        axi_write(IRQ_STATUS_ADDR, 32'h03, rs);
        repeat (2) @(posedge clk);
        #1 chk("irq cleared", 32'h0, {31'h0, irq});
        axi_read(IRQ_STATUS_ADDR, rd, rs);
        chk("status cleared", 32'h00, rd);
        // test register stores its bits and its bit 0 raises the test status
        axi_write(INTERRUPT_TEST_CONTROL_ADDR, 32'hA5, rs);
        axi_read(INTERRUPT_TEST_CONTROL_ADDR, rd, rs);
        chk("test readback", 32'hA5, rd);
        axi_read(IRQ_STATUS_ADDR, rd, rs);
        chk("status test bit", 32'h04, rd);
        // queue register ignores writes; unmapped place answers with an error
        axi_write(TONE_EVENT_QUEUE_ADDR, 32'h9F, rs);
        chk("queue write resp", {30'h0, RESP_OKAY}, {30'h0, rs});
        axi_read(TONE_EVENT_QUEUE_ADDR, rd, rs);
        chk("queue unwritten", 32'h00, rd);
        axi_read(14'h0000, rd, rs);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        chk("unmapped data", 32'h0, rd);
        axi_write(14'h0000, 32'h01, rs);
        chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        // a reset in mid-run empties a queue that still holds an entry
        @(posedge clk);
        evt <= '{valid: 1'b1, code: 5'h0A};
        @(posedge clk);
        evt <= '0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        axi_read(TONE_EVENT_QUEUE_ADDR, rd, rs);
        chk("queue after mid reset", 32'h00, rd);
        axi_read(INTERRUPT_TEST_CONTROL_ADDR, rd, rs);
        chk("test after mid reset", 32'h00, rd);
        end_of_test();
    end
endmodule
`default_nettype wire
